// File: pkg/mpc_pkg.sv
package mpc_pkg;
    // ==========================================
    // Register indices on the software port.
    localparam logic [3:0] MPC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] MPC_ADDR_PORT5_DATA = 4'h1;
    localparam logic [3:0] MPC_ADDR_PORT5_DIR = 4'h5;
    localparam logic [3:0] MPC_ADDR_PORT6_DIR = 4'h6;
    localparam logic [3:0] MPC_ADDR_AMP_CFG = 4'h9;
    localparam logic [3:0] MPC_ADDR_CONV_CFG = 4'ha;
    localparam logic [3:0] MPC_ADDR_PULLDOWN = 4'hb;
    localparam logic [3:0] MPC_ADDR_OPEN_DRAIN = 4'hc;
    localparam logic [3:0] MPC_ADDR_PULLHIGH = 4'hd;
    localparam logic [3:0] MPC_ADDR_WATCHDOG = 4'he;
    localparam logic [3:0] MPC_ADDR_IRQ_MASK = 4'hf;
    localparam logic [3:0] MPC_ADDR_IRQ_STATUS = 4'h7;
    // ==========================================
    // Reset values.
    localparam logic [7:0] MPC_RST_CONTROL = 8'h3f;
    localparam logic [7:0] MPC_RST_DIR = 8'hff;
    localparam logic [7:0] MPC_RST_ZERO = 8'h00;
    localparam logic [7:0] MPC_RST_PULL = 8'hff;
    // ==========================================
    // Field positions and masks.
    localparam int MPC_BIT_EDGE = 7;
    localparam int MPC_BIT_GIE = 6;
    localparam int MPC_BIT_SRC = 5;
    localparam int MPC_BIT_CEDGE = 4;
    localparam int MPC_BIT_OWNER = 3;
    localparam int MPC_BIT_WDT_ON = 7;
    localparam int MPC_BIT_EIS = 6;
    localparam int MPC_IRQ_EXT = 2;
    localparam logic [7:0] MPC_MASK_PULLHIGH = 8'hef;
    localparam logic [7:0] MPC_MASK_WATCHDOG = 8'hc0;
    localparam logic [7:0] MPC_MASK_IRQ = 8'h7f;
    localparam logic [2:0] MPC_GAIN2_MAX = 3'h5;
    localparam logic [2:0] MPC_GAIN1_MAX = 3'h4;
    // Instruction sequencer states for global enable.
    typedef enum logic [2:0] {
        MPC_RUN = 3'b001,
        MPC_ENTER = 3'b010,
        MPC_IN_IRQ = 3'b100
    } mpc_state_t;
endpackage : mpc_pkg

// File: hdl/mpc_regs.sv
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mpc_regs
    import mpc_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Software register port.
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Instruction events.
    input wire logic GLOBAL_ENABLE_INSTRUCTION,
    input wire logic GLOBAL_DISABLE_INSTRUCTION,
    input wire logic RETURN_FROM_IRQ_INSTRUCTION,
    input wire logic IRQ_ACK,
    // Pins and hardware events.
    input wire logic [7:0] PORT5_PIN,
    input wire logic COUNTER_PIN,
    input wire logic [6:0] IRQ_EVENT,
    // Processor request and derived controls.
    output logic IRQ_TO_CPU,
    output logic COUNT_TICK,
    output logic [7:0] TIMER_DIV_MASK,
    output logic [7:0] WATCHDOG_DIV_MASK,
    output logic [7:0] PORT5_OE,
    output logic [7:0] PORT6_OE,
    output logic [7:0] PORT6_ANALOG,
    output logic [7:0] PULLDOWN_EN,
    output logic [7:0] OPENDRAIN_EN,
    output logic [7:0] PULLHIGH_EN,
    output logic AMP1_ON,
    output logic AMP2_ON,
    output logic [2:0] AMP1_GAIN,
    output logic [2:0] AMP2_GAIN,
    output logic REF_FROM_PIN,
    output logic COMPARATOR_ON,
    output logic COMPARATOR_DRIVES_PIN,
    output logic [1:0] CONV_CLOCK_SEL,
    output logic WATCHDOG_RUN
);
    import mpc_pkg::*;

    // ==========================================
    // Register storage.
    logic [7:0] control;
    logic [7:0] port5_direction;
    logic [7:0] port6_direction;
    logic [7:0] amplifier_config;
    logic [7:0] converter_comparator_config;
    logic [7:0] pulldown_control;
    logic [7:0] open_drain_control;
    logic [7:0] pullhigh_control;
    logic [7:0] watchdog_control;
    logic [7:0] interrupt_mask;
    logic [6:0] pending;
    logic int_pin_q;
    logic cnt_pin_q;
    mpc_state_t state;

    // ==========================================
    // Decode of write strobes.
    wire wr_control = WR && ADDR == MPC_ADDR_CONTROL;
    wire wr_p5dir = WR && ADDR == MPC_ADDR_PORT5_DIR;
    wire wr_p6dir = WR && ADDR == MPC_ADDR_PORT6_DIR;
    wire wr_amp = WR && ADDR == MPC_ADDR_AMP_CFG;
    wire wr_conv = WR && ADDR == MPC_ADDR_CONV_CFG;
    wire wr_pd = WR && ADDR == MPC_ADDR_PULLDOWN;
    wire wr_od = WR && ADDR == MPC_ADDR_OPEN_DRAIN;
    wire wr_ph = WR && ADDR == MPC_ADDR_PULLHIGH;
    wire wr_wdt = WR && ADDR == MPC_ADDR_WATCHDOG;
    wire wr_mask = WR && ADDR == MPC_ADDR_IRQ_MASK;
    wire wr_status = WR && ADDR == MPC_ADDR_IRQ_STATUS;

    // External pin is only seen when its function is selected; else the path is masked.
    wire ext_path_on = watchdog_control[MPC_BIT_EIS];
    wire int_pin = PORT5_PIN[0];
    wire int_rise = int_pin && !int_pin_q;
    wire int_fall = !int_pin && int_pin_q;
    wire ext_edge = ext_path_on && (control[MPC_BIT_EDGE] ? int_fall : int_rise);
    wire cnt_rise = COUNTER_PIN && !cnt_pin_q;
    wire cnt_fall = !COUNTER_PIN && cnt_pin_q;
    wire pin_tick = control[MPC_BIT_CEDGE] ? cnt_fall : cnt_rise;
    wire next_count_tick = control[MPC_BIT_SRC] ? pin_tick : 1'b1;

    // Hardware events, with the external edge folded into its own source.
    logic [6:0] events;
    always_comb begin
        events = IRQ_EVENT;
        events[MPC_IRQ_EXT] = IRQ_EVENT[MPC_IRQ_EXT] | ext_edge;
    end

    // Writing a one keeps the flag, a zero clears it; hardware sets win over the clear.
    wire [6:0] next_pending = (wr_status ? (pending & WDATA[6:0]) : pending) | events;
    wire [6:0] active = pending & interrupt_mask[6:0];
    wire next_irq = (|active) && control[MPC_BIT_GIE] && state == MPC_RUN;

    // Prescaler divide masks: counter 2^(n+1), watchdog 2^n, the other side passes through.
    wire [8:0] tdiv_full = 9'h002 << control[2:0];
    wire [8:0] wdiv_full = 9'h001 << control[2:0];
    wire [7:0] next_tdiv = control[MPC_BIT_OWNER] ? 8'h00 : 8'((tdiv_full - 9'h001) & 9'h0ff);
    wire [7:0] next_wdiv = control[MPC_BIT_OWNER] ? 8'((wdiv_full - 9'h001) & 9'h0ff) : 8'h00;

    // Port 6 analog pins 0..k, a thermometer code.
    wire [8:0] analog_full = 9'h002 << converter_comparator_config[4:2];
    wire [7:0] next_analog = 8'(analog_full - 9'h001);

    // Open-drain and pull-high enables keep the register's bit order: lane n is register bit n.
    // One 8-bit lane set cannot carry pins of two ports by pin number without port 5 pins 1 and 2
    // colliding with port 6 lanes, so the pad ring applies the final pin mapping.
    wire [7:0] next_od = ~open_drain_control;
    wire [7:0] next_ph = ~pullhigh_control & MPC_MASK_PULLHIGH;

    // Read mux; port 5 read returns the live pin levels, including pin 0.
    logic [7:0] next_rdata;
    always_comb begin
        case (ADDR)
            MPC_ADDR_CONTROL: next_rdata = control;
            MPC_ADDR_PORT5_DATA: next_rdata = PORT5_PIN;
            MPC_ADDR_PORT5_DIR: next_rdata = port5_direction;
            MPC_ADDR_PORT6_DIR: next_rdata = port6_direction;
            MPC_ADDR_AMP_CFG: next_rdata = amplifier_config;
            MPC_ADDR_CONV_CFG: next_rdata = converter_comparator_config;
            MPC_ADDR_PULLDOWN: next_rdata = pulldown_control;
            MPC_ADDR_OPEN_DRAIN: next_rdata = open_drain_control;
            MPC_ADDR_PULLHIGH: next_rdata = pullhigh_control;
            MPC_ADDR_WATCHDOG: next_rdata = watchdog_control;
            MPC_ADDR_IRQ_MASK: next_rdata = interrupt_mask;
            MPC_ADDR_IRQ_STATUS: next_rdata = {1'b0, active};
            default: next_rdata = 8'h00;
        endcase
    end

    // Global enable sequencing: entry clears the flag, return restores it.
    logic [7:0] next_control;
    mpc_state_t next_state;
    always_comb begin
        next_control = wr_control ? WDATA : control;
        next_state = state;
        case (state)
            MPC_RUN: begin
                if (IRQ_ACK) begin
                    next_state = MPC_ENTER;
                end
            end
            MPC_ENTER: next_state = MPC_IN_IRQ;
            MPC_IN_IRQ: begin
                if (RETURN_FROM_IRQ_INSTRUCTION) begin
                    next_state = MPC_RUN;
                end
            end
            default: next_state = MPC_RUN;
        endcase
        if (GLOBAL_ENABLE_INSTRUCTION || RETURN_FROM_IRQ_INSTRUCTION) begin
            next_control[MPC_BIT_GIE] = 1'b1;
        end
        if (GLOBAL_DISABLE_INSTRUCTION || IRQ_ACK) begin
            next_control[MPC_BIT_GIE] = 1'b0;
        end
    end

    // ==========================================
    // Software-written registers.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            control <= MPC_RST_CONTROL;
            port5_direction <= MPC_RST_DIR;
            port6_direction <= MPC_RST_DIR;
            amplifier_config <= MPC_RST_ZERO;
            converter_comparator_config <= MPC_RST_ZERO;
            pulldown_control <= MPC_RST_PULL;
            open_drain_control <= MPC_RST_PULL;
            pullhigh_control <= MPC_RST_PULL & MPC_MASK_PULLHIGH;
            watchdog_control <= MPC_RST_ZERO;
            interrupt_mask <= MPC_RST_ZERO;
        end else begin
            control <= next_control;
            if (wr_p5dir) port5_direction <= WDATA;
            if (wr_p6dir) port6_direction <= WDATA;
            if (wr_amp) amplifier_config <= WDATA;
            if (wr_conv) converter_comparator_config <= WDATA;
            if (wr_pd) pulldown_control <= WDATA;
            if (wr_od) open_drain_control <= WDATA;
            if (wr_ph) pullhigh_control <= WDATA & MPC_MASK_PULLHIGH;
            if (wr_wdt) watchdog_control <= WDATA & MPC_MASK_WATCHDOG;
            if (wr_mask) interrupt_mask <= WDATA & MPC_MASK_IRQ;
        end
    end

    // ==========================================
    // Flags, edge history, sequencer and registered outputs.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pending <= 7'h00;
            int_pin_q <= 1'b0;
            cnt_pin_q <= 1'b0;
            state <= MPC_RUN;
            RDATA <= 8'h00;
            IRQ_TO_CPU <= 1'b0;
            COUNT_TICK <= 1'b0;
            TIMER_DIV_MASK <= 8'h00;
            WATCHDOG_DIV_MASK <= 8'h00;
        end else begin
            pending <= next_pending;
            int_pin_q <= int_pin;
            cnt_pin_q <= COUNTER_PIN;
            state <= next_state;
            RDATA <= RD ? next_rdata : 8'h00;
            IRQ_TO_CPU <= next_irq;
            COUNT_TICK <= next_count_tick;
            TIMER_DIV_MASK <= next_tdiv;
            WATCHDOG_DIV_MASK <= next_wdiv;
        end
    end

    // Pin and analog configuration outputs, registered so they track the stored words.
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PORT5_OE <= 8'h00;
            PORT6_OE <= 8'h00;
            PORT6_ANALOG <= 8'h00;
            PULLDOWN_EN <= 8'h00;
            OPENDRAIN_EN <= 8'h00;
            PULLHIGH_EN <= 8'h00;
            AMP1_ON <= 1'b0;
            AMP2_ON <= 1'b0;
            AMP1_GAIN <= 3'h0;
            AMP2_GAIN <= 3'h0;
            REF_FROM_PIN <= 1'b0;
            COMPARATOR_ON <= 1'b0;
            COMPARATOR_DRIVES_PIN <= 1'b0;
            CONV_CLOCK_SEL <= 2'h0;
            WATCHDOG_RUN <= 1'b0;
        end else begin
            // Pin 0 of port 5 never drives while it is the interrupt input.
            PORT5_OE <= ~port5_direction & {7'h7f, ~ext_path_on};
            PORT6_OE <= ~port6_direction;
            PORT6_ANALOG <= next_analog;
            PULLDOWN_EN <= ~pulldown_control;
            OPENDRAIN_EN <= next_od;
            PULLHIGH_EN <= next_ph;
            AMP2_ON <= amplifier_config[7];
            AMP1_ON <= amplifier_config[6];
            // Codes above the top gain are clamped; the amplifiers have no higher step.
            AMP2_GAIN <= (amplifier_config[5:3] > MPC_GAIN2_MAX) ? MPC_GAIN2_MAX : amplifier_config[5:3];
            AMP1_GAIN <= (amplifier_config[2:0] > MPC_GAIN1_MAX) ? MPC_GAIN1_MAX : amplifier_config[2:0];
            REF_FROM_PIN <= converter_comparator_config[7];
            COMPARATOR_ON <= converter_comparator_config[6];
            COMPARATOR_DRIVES_PIN <= converter_comparator_config[6] & converter_comparator_config[5];
            CONV_CLOCK_SEL <= converter_comparator_config[1:0];
            WATCHDOG_RUN <= watchdog_control[MPC_BIT_WDT_ON];
        end
    end

    // ==========================================
    // Checks.
    property p_ext_rise;
        @(posedge CLK) disable iff (SYS_RST)
        ext_path_on && !control[MPC_BIT_EDGE] && int_rise |=> pending[MPC_IRQ_EXT];
    endproperty
    a_ext_rise: assert property (p_ext_rise) else $error("rising edge not flagged");

    property p_gie_off;
        @(posedge CLK) disable iff (SYS_RST)
        GLOBAL_DISABLE_INSTRUCTION |=> !control[MPC_BIT_GIE] ##1 !IRQ_TO_CPU;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("global disable ignored");

    property p_src_internal;
        @(posedge CLK) disable iff (SYS_RST)
        !control[MPC_BIT_SRC] |=> COUNT_TICK;
    endproperty
    a_src_internal: assert property (p_src_internal) else $error("internal tick missing");

    property p_wdiv;
        @(posedge CLK) disable iff (SYS_RST)
        control[MPC_BIT_OWNER] && control[2:0] == 3'h7 |=> WATCHDOG_DIV_MASK == 8'h7f && TIMER_DIV_MASK == 8'h00;
    endproperty
    a_wdiv: assert property (p_wdiv) else $error("watchdog ratio wrong");

    property p_status_and;
        @(posedge CLK) disable iff (SYS_RST)
        RD && ADDR == MPC_ADDR_IRQ_STATUS |=> RDATA == {1'b0, $past(pending) & $past(interrupt_mask[6:0])};
    endproperty
    a_status_and: assert property (p_status_and) else $error("status read not masked");

    property p_no_sw_set;
        @(posedge CLK) disable iff (SYS_RST)
        wr_status && IRQ_EVENT == 7'h00 && !ext_edge |=> (pending & ~$past(pending)) == 7'h00;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) else $error("software set a flag");

    property p_mask_top;
        @(posedge CLK) disable iff (SYS_RST)
        RD && ADDR == MPC_ADDR_IRQ_MASK |=> !RDATA[7];
    endproperty
    a_mask_top: assert property (p_mask_top) else $error("mask bit 7 not zero");

    property p_write_back;
        @(posedge CLK) disable iff (SYS_RST)
        wr_amp |=> amplifier_config == $past(WDATA);
    endproperty
    a_write_back: assert property (p_write_back) else $error("readback mismatch");

    property p_irq_gate;
        @(posedge CLK) disable iff (SYS_RST)
        IRQ_TO_CPU |-> $past(control[MPC_BIT_GIE]) && $past(|active);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request passed without enables");
endmodule : mpc_regs

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import mpc_pkg::*;
    // ==========================================
    // Stimulus and observed signals.
    logic clk, sys_rst, wr, rd, en_i, dis_i, ret_i, ack_i, cnt_pin;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, p5_pin, d;
    logic [6:0] irq_ev;
    logic irq, tick, amp1_on, amp2_on, ref_pin, cmp_on, cmp_pin, wdt_run;
    logic [7:0] tmask, wmask, p5_oe, p6_oe, p6_an, pd_en, od_en, ph_en;
    logic [2:0] g1, g2;
    logic [1:0] cclk;
    int mismatches = 0;
    int compares = 0;
    int n;
    mpc_regs dut_u (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .GLOBAL_ENABLE_INSTRUCTION(en_i), .GLOBAL_DISABLE_INSTRUCTION(dis_i),
        .RETURN_FROM_IRQ_INSTRUCTION(ret_i), .IRQ_ACK(ack_i), .PORT5_PIN(p5_pin), .COUNTER_PIN(cnt_pin),
        .IRQ_EVENT(irq_ev), .IRQ_TO_CPU(irq), .COUNT_TICK(tick), .TIMER_DIV_MASK(tmask),
        .WATCHDOG_DIV_MASK(wmask), .PORT5_OE(p5_oe), .PORT6_OE(p6_oe), .PORT6_ANALOG(p6_an),
        .PULLDOWN_EN(pd_en), .OPENDRAIN_EN(od_en), .PULLHIGH_EN(ph_en), .AMP1_ON(amp1_on), .AMP2_ON(amp2_on),
        .AMP1_GAIN(g1), .AMP2_GAIN(g2), .REF_FROM_PIN(ref_pin), .COMPARATOR_ON(cmp_on),
        .COMPARATOR_DRIVES_PIN(cmp_pin), .CONV_CLOCK_SEL(cclk), .WATCHDOG_RUN(wdt_run));
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================
    // Shared bus tasks and comparisons.
    task automatic close_out();
        $display("Counts: compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_reg
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    // Instruction pulses: 0 enable, 1 disable, 2 return, 3 entry.
    task automatic instr(input int which);
        @(posedge clk);
        {ack_i, ret_i, dis_i, en_i} <= 4'(1 << which);
        @(posedge clk);
        {ack_i, ret_i, dis_i, en_i} <= 4'h0;
    endtask : instr
    // ==========================================
    // Scenarios.
    task automatic test_reset();
        rd_reg(MPC_ADDR_CONTROL, d); cmp(d, 8'h3f);
        rd_reg(MPC_ADDR_PORT5_DIR, d); cmp(d, 8'hff);
        rd_reg(MPC_ADDR_PULLHIGH, d); cmp(d, 8'hef);
        rd_reg(MPC_ADDR_IRQ_MASK, d); cmp(d, 8'h00);
        rd_reg(4'h2, d); cmp(d, 8'h00);
        cmp(wmask, 8'h7f);
        cmp(tmask, 8'h00);
        cmp(p6_an, 8'h01);
        cmp(pd_en, 8'h00);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_readback();
        wr_reg(MPC_ADDR_PORT6_DIR, 8'h5a);
        wr_reg(4'h3, 8'h77);
        wr_reg(MPC_ADDR_PULLHIGH, 8'h00);
        wr_reg(MPC_ADDR_WATCHDOG, 8'hff);
        wr_reg(MPC_ADDR_IRQ_MASK, 8'hff);
        wr_reg(MPC_ADDR_OPEN_DRAIN, 8'ha5);
        rd_reg(MPC_ADDR_PORT6_DIR, d); cmp(d, 8'h5a);
        rd_reg(4'h3, d); cmp(d, 8'h00);
        rd_reg(MPC_ADDR_PULLHIGH, d); cmp(d, 8'h00);
        rd_reg(MPC_ADDR_WATCHDOG, d); cmp(d, 8'hc0);
        rd_reg(MPC_ADDR_IRQ_MASK, d); cmp(d, 8'h7f);
        rd_reg(MPC_ADDR_OPEN_DRAIN, d); cmp(d, 8'ha5);
        settle();
        cmp(p6_oe, 8'ha5);
        cmp({7'h0, wdt_run}, 8'h01);
        cmp(od_en, 8'h5a);
        cmp(ph_en, 8'hef);
        wr_reg(MPC_ADDR_WATCHDOG, 8'h00);
        wr_reg(MPC_ADDR_IRQ_MASK, 8'h00);
        $display("test_readback done");
    endtask : test_readback
    task automatic test_prescaler();
        for (n = 0; n < 8; n++) begin
            wr_reg(MPC_ADDR_CONTROL, 8'(n));
            settle();
            cmp(tmask, 8'hff >> (7 - n));
            cmp(wmask, 8'h00);
            wr_reg(MPC_ADDR_CONTROL, 8'(8 + n));
            settle();
            cmp(wmask, 8'hff >> (8 - n));
            cmp(tmask, 8'h00);
        end
        $display("test_prescaler done");
    endtask : test_prescaler
    task automatic test_analog();
        for (n = 0; n < 8; n++) begin
            wr_reg(MPC_ADDR_CONV_CFG, 8'((n << 2) | (n & 3)));
            settle();
            cmp(p6_an, 8'hff >> (7 - n));
            cmp({6'h0, cclk}, 8'(n & 3));
        end
        wr_reg(MPC_ADDR_CONV_CFG, 8'ha0);
        settle();
        cmp({5'h0, ref_pin, cmp_on, cmp_pin}, 8'h04);
        wr_reg(MPC_ADDR_CONV_CFG, 8'h60);
        settle();
        cmp({5'h0, ref_pin, cmp_on, cmp_pin}, 8'h03);
        wr_reg(MPC_ADDR_AMP_CFG, 8'h7f);
        rd_reg(MPC_ADDR_AMP_CFG, d); cmp(d, 8'h7f);
        wr_reg(MPC_ADDR_PULLDOWN, 8'h3c);
        settle();
        cmp({amp2_on, amp1_on, g2, g1}, {2'b01, MPC_GAIN2_MAX, MPC_GAIN1_MAX});
        cmp(pd_en, 8'hc3);
        wr_reg(MPC_ADDR_AMP_CFG, 8'h9a);
        settle();
        cmp({amp2_on, amp1_on, g2, g1}, 8'h9a);
        $display("test_analog done");
    endtask : test_analog
    task automatic count_ticks(input int cyc, input logic [7:0] exp);
        int c;
        c = 0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            if (tick === 1'b1) c++;
        end
        cmp(8'(c), exp);
    endtask : count_ticks
    task automatic test_counter();
        wr_reg(MPC_ADDR_CONTROL, 8'h00);
        settle();
        count_ticks(6, 8'd6);
        wr_reg(MPC_ADDR_CONTROL, 8'h20);
        settle();
        cnt_pin <= 1'b1;
        count_ticks(6, 8'd1);
        cnt_pin <= 1'b0;
        count_ticks(6, 8'd0);
        wr_reg(MPC_ADDR_CONTROL, 8'h30);
        settle();
        cnt_pin <= 1'b1;
        count_ticks(6, 8'd0);
        cnt_pin <= 1'b0;
        count_ticks(6, 8'd1);
        $display("test_counter done");
    endtask : test_counter
    task automatic wait_irq(input logic exp);
        int k;
        for (k = 0; k < 8 && irq !== exp; k++) @(posedge clk);
        #1;
        cmp({7'h0, irq}, {7'h0, exp});
        if (irq !== exp) close_out();
    endtask : wait_irq
    task automatic test_irq();
        wr_reg(MPC_ADDR_CONTROL, 8'h00);
        wr_reg(MPC_ADDR_IRQ_MASK, 8'h01);
        instr(0);
        rd_reg(MPC_ADDR_CONTROL, d); cmp(d, 8'h40);
        @(posedge clk);
        irq_ev <= 7'h01;
        @(posedge clk);
        irq_ev <= 7'h00;
        rd_reg(MPC_ADDR_IRQ_STATUS, d); cmp(d, 8'h01);
        wait_irq(1'b1);
        wr_reg(MPC_ADDR_IRQ_MASK, 8'h00);
        rd_reg(MPC_ADDR_IRQ_STATUS, d); cmp(d, 8'h00);
        wait_irq(1'b0);
        wr_reg(MPC_ADDR_IRQ_MASK, 8'h01);
        wait_irq(1'b1);
        instr(1);
        wait_irq(1'b0);
        rd_reg(MPC_ADDR_CONTROL, d); cmp(d, 8'h00);
        instr(2);
        wait_irq(1'b1);
        instr(3);
        rd_reg(MPC_ADDR_CONTROL, d); cmp(d, 8'h00);
        instr(0);
        wr_reg(MPC_ADDR_IRQ_STATUS, 8'hfe);
        rd_reg(MPC_ADDR_IRQ_STATUS, d); cmp(d, 8'h00);
        wait_irq(1'b0);
        wr_reg(MPC_ADDR_IRQ_MASK, 8'h7f);
        wr_reg(MPC_ADDR_IRQ_STATUS, 8'hff);
        rd_reg(MPC_ADDR_IRQ_STATUS, d); cmp(d, 8'h00);
        @(posedge clk);
        irq_ev <= 7'h7f;
        @(posedge clk);
        irq_ev <= 7'h00;
        rd_reg(MPC_ADDR_IRQ_STATUS, d); cmp(d, 8'h7f);
        wr_reg(MPC_ADDR_IRQ_STATUS, 8'h00);
        $display("test_irq done");
    endtask : test_irq
    task automatic test_ext_pin();
        wr_reg(MPC_ADDR_PORT5_DIR, 8'h00);
        wr_reg(MPC_ADDR_WATCHDOG, 8'h40);
        wr_reg(MPC_ADDR_IRQ_MASK, 8'h04);
        settle();
        cmp(p5_oe, 8'hfe);
        p5_pin <= 8'h81;
        settle();
        rd_reg(MPC_ADDR_IRQ_STATUS, d); cmp(d, 8'h04);
        rd_reg(MPC_ADDR_PORT5_DATA, d); cmp(d, 8'h81);
        wr_reg(MPC_ADDR_IRQ_STATUS, 8'h00);
        wr_reg(MPC_ADDR_CONTROL, 8'h80);
        p5_pin <= 8'h80;
        settle();
        rd_reg(MPC_ADDR_IRQ_STATUS, d); cmp(d, 8'h04);
        wr_reg(MPC_ADDR_IRQ_STATUS, 8'h00);
        wr_reg(MPC_ADDR_WATCHDOG, 8'h00);
        p5_pin <= 8'h01;
        settle();
        p5_pin <= 8'h00;
        settle();
        cmp(p5_oe, 8'hff);
        rd_reg(MPC_ADDR_IRQ_STATUS, d); cmp(d, 8'h00);
        $display("test_ext_pin done");
    endtask : test_ext_pin
    // A second reset in mid-run must bring back the reset contents.
    task automatic test_midreset();
        wr_reg(MPC_ADDR_PORT5_DIR, 8'h00);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd_reg(MPC_ADDR_PORT5_DIR, d); cmp(d, 8'hff);
        $display("test_midreset done");
    endtask : test_midreset
    // ==========================================
    // Main sequence.
    initial begin
        {sys_rst, wr, rd, en_i, dis_i, ret_i, ack_i, cnt_pin} = 8'h80;
        addr = 4'h0;
        wdata = 8'h00;
        p5_pin = 8'h00;
        irq_ev = 7'h00;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        settle();
        test_reset();
        test_readback();
        test_prescaler();
        test_analog();
        test_counter();
        test_irq();
        test_ext_pin();
        test_midreset();
        close_out();
    end
endmodule : testbench
